// ---- include/timer16_defines.vh ----
// Register map, field positions and timing constants of the 16-bit timer
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH
// Register indices as printed, byte address is four times the index
`define CTRL_A_IDX 8'h2f
`define CTRL_B_IDX 8'h2e
`define CTRL_A_ADDR 12'h0bc
`define CTRL_B_ADDR 12'h0b8
`define COUNT_ADDR 12'h000
`define CMP_A_ADDR 12'h004
`define CMP_B_ADDR 12'h008
`define CAPT_ADDR 12'h00c
`define STATUS_ADDR 12'h010
`define MASK_ADDR 12'h014
`define CTRL_A_RESET 8'h00
`define CTRL_A_RW_MASK 8'hf3
`define CTRL_B_RW_MASK 8'hef
// Control A fields
`define CA_MODE_A_HI 7
`define CA_MODE_A_LO 6
`define CA_MODE_B_HI 5
`define CA_MODE_B_LO 4
// Control B fields
`define CB_NOISE 7
`define CB_EDGE 6
`define CB_COMP 5
`define CB_CLEAR_A 3
// Clock select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
// PWM select codes
`define PWM_OFF 2'h0
`define PWM_8 2'h1
`define PWM_9 2'h2
`define PWM_10 2'h3
// Compare pin actions
`define CM_OFF 2'h0
`define CM_TOGGLE 2'h1
`define CM_CLEAR 2'h2
`define CM_SET 2'h3
// Status bit positions
`define ST_OVF 0
`define ST_CMP_A 1
`define ST_CMP_B 2
`define ST_CAPT 3
`define NOISE_SAMPLES 4
`endif

// ---- tb/timer16_props.sv ----
// Concurrent checks on the APB side and outputs of the 16-bit timer
`include "timer16_defines.vh"
module timer16_props (
  input wire ref_clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire compare_oe_a_o,
  input wire compare_oe_b_o,
  input wire irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Helpers
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  reg ca_wr_q;
  // Remembers a taken write to control A
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) ca_wr_q <= 1'b0;
    else if (psel_i && penable_i && pwrite_i && paddr_i == `CTRL_A_ADDR) ca_wr_q <= 1'b1;
  end
  sequence s_req;
    psel_i && !penable_i ##1 psel_i && penable_i && !pready_o;
  endsequence
  sequence s_rd_ctrl_a;
    pready_o && psel_i && !pwrite_i && paddr_i == `CTRL_A_ADDR;
  endsequence
  // ==========================================
  // Properties
  a_ready_one_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_answer_timing: assert property (s_req |=> pready_o)
    else $error("ready not on second access edge");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_idle_no_ready: assert property (!psel_i |-> !pready_o)
    else $error("ready while idle");
  a_reserved_zero: assert property (s_rd_ctrl_a |-> prdata_o[3:2] == 2'b00)
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(rst_i) |-> !compare_oe_a_o && !compare_oe_b_o && !irq_o)
    else $error("outputs not idle after reset");
  a_oe_needs_write: assert property ($rose(compare_oe_a_o) || $rose(compare_oe_b_o) |-> ca_wr_q)
    else $error("pin drive without mode write");
endmodule
bind timer16 timer16_props u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .compare_oe_a_o(compare_oe_a_o),
  .compare_oe_b_o(compare_oe_b_o), .irq_o(irq_o));

// ---- tb/timer16_tb.sv ----
// Self-checking bench for the 16-bit timer
`include "timer16_defines.vh"
`define chk(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module timer16_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, cpin = 0, kpin = 0, comp = 0, er;
  reg [11:0] pa = 0;
  reg [31:0] pwd = 0, rd;
  wire [31:0] prd;
  wire prdy, perr, pin_a, pin_b, oa, ob, irq;
  integer compares = 0, mismatches = 0, i, k, hi;
  // ==========================================
  // Clock, design and tasks
  always #5 clk = ~clk;
  timer16 DUT (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .count_pin_i(kpin), .capture_pin_i(cpin), .comparator_i(comp), .compare_pin_a_o(pin_a),
    .compare_pin_b_o(pin_b), .compare_oe_a_o(oa), .compare_oe_b_o(ob), .irq_o(irq));
  task apb(input bit w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 50);
      if (prdy !== 1'b1) mismatches++;
      rd = prd;
      er = perr;
      psel <= 0; pen <= 0;
    end
  endtask
  task settle(input integer n);
    begin repeat (n) @(posedge clk); end
  endtask
  // Four clocks between pin transitions
  task pulses;
    for (k = 0; k < 5; k++) begin
      repeat (4) @(posedge clk); kpin <= 1;
      repeat (4) @(posedge clk); kpin <= 0;
    end
  endtask
  task run_match(input [7:0] ca);
    begin
      apb(1, `CTRL_B_ADDR, 0); apb(1, `COUNT_ADDR, 0);
      apb(1, `CTRL_A_ADDR, ca); apb(1, `CTRL_B_ADDR, `CS_DIV1); // Mask is zero
      settle(40); apb(1, `CTRL_B_ADDR, 0); settle(3);
    end
  endtask
  task t_regs;
    begin
      apb(0, `CTRL_A_ADDR, 0); `chk(rd[7:0], 8'h00)
      apb(1, `CTRL_A_ADDR, 32'h0000_00ff); apb(0, `CTRL_A_ADDR, 0);
      `chk(rd[7:0], 8'hf3)
      apb(0, 12'h100, 0); `chk({er, rd}, {1'b1, 32'h0000_0000})
      apb(1, `CTRL_A_ADDR, 0);
    end
  endtask
  task t_compare;
    reg [1:0] cm;
    for (i = 0; i < 4; i++) begin
      cm = 2'h3 - i[1:0];
      apb(1, `CMP_A_ADDR, 16'h0014); apb(1, `CMP_B_ADDR, 16'h001e);
      run_match({cm, cm, 4'h0});
      `chk({oa, ob}, {2{cm != `CM_OFF}})
      if (cm != `CM_OFF) `chk({pin_a, pin_b}, {2{cm != `CM_CLEAR}})
    end
  endtask
  task t_irq;
    begin
      apb(1, `STATUS_ADDR, 4'hf); run_match(8'h00); apb(1, `CTRL_B_ADDR, 0);
      apb(1, `STATUS_ADDR, 0); apb(0, `STATUS_ADDR, 0);
      `chk({irq, rd[2:1]}, 3'h3)
      apb(1, `MASK_ADDR, 4'h2); settle(3); `chk(irq, 1'b1)
      apb(1, `STATUS_ADDR, 4'h2); settle(3); `chk(irq, 1'b0)
      apb(1, `MASK_ADDR, 0);
    end
  endtask
  task t_clear_on_a;
    begin
      apb(1, `CMP_A_ADDR, 16'h000a); apb(1, `COUNT_ADDR, 0);
      apb(1, `CTRL_B_ADDR, 8'h08 | `CS_DIV1); settle(100);
      apb(1, `CTRL_B_ADDR, 0); apb(0, `COUNT_ADDR, 0);
      `chk(rd[15:0] <= 16'h000a, 1'b1)
    end
  endtask
  task t_ext;
    begin
      apb(1, `COUNT_ADDR, 0); apb(1, `CTRL_B_ADDR, `CS_EXT_RISE);
      pulses; settle(8); apb(1, `CTRL_B_ADDR, `CS_STOP); pulses; settle(8);
      apb(0, `COUNT_ADDR, 0); `chk(rd[15:0], 16'h0005)
    end
  endtask
  task t_capture;
    begin
      apb(1, `STATUS_ADDR, 4'hf); apb(1, `CTRL_B_ADDR, `CS_DIV1);
      cpin <= 1; settle(12); apb(0, `STATUS_ADDR, 0); `chk(rd[3], 1'b0)
      cpin <= 0; settle(12); apb(0, `STATUS_ADDR, 0); `chk(rd[3], 1'b1)
      apb(0, `CAPT_ADDR, 0); `chk(rd[15:0] != 0, 1'b1)
      apb(1, `STATUS_ADDR, 4'hf); apb(1, `CTRL_B_ADDR, 8'hc0 | `CS_DIV1);
      cpin <= 1; settle(2); cpin <= 0; settle(12);
      apb(0, `STATUS_ADDR, 0); `chk(rd[3], 1'b0)
      cpin <= 1; settle(12); apb(0, `STATUS_ADDR, 0); `chk(rd[3], 1'b1)
      comp <= 1; settle(12); apb(1, `STATUS_ADDR, 4'hf);
      apb(1, `CTRL_B_ADDR, 8'h20 | `CS_DIV1); comp <= 0; settle(12);
      apb(0, `STATUS_ADDR, 0); `chk(rd[3], 1'b1)
      apb(1, `CTRL_B_ADDR, 0);
    end
  endtask
  task t_pwm;
    for (i = 1; i < 4; i++) begin
      apb(1, `CMP_A_ADDR, 16'h0040); apb(1, `COUNT_ADDR, 0);
      apb(1, `CTRL_A_ADDR, {6'h20, i[1:0]}); apb(1, `CTRL_B_ADDR, `CS_DIV1);
      settle(2 * ((256 << (i - 1)) - 1));
      hi = 0;
      for (k = 0; k < 2 * ((256 << (i - 1)) - 1); k++) begin @(posedge clk); hi += pin_a; end
      `chk(hi >= 124 && hi <= 132, 1'b1)
    end
  endtask
  task give_verdict;
    begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs; t_compare; t_irq; t_clear_on_a; t_ext; t_capture; t_pwm;
    give_verdict;
  end
  initial begin
    #500_000;
    mismatches++;
    give_verdict;
  end
endmodule

// ---- verilog/capture_filter.v ----
// Capture edge detector with optional four-sample noise canceler
`include "timer16_defines.vh"
module capture_filter (
  input wire ref_clk_i,
  input wire rst_i,
  input wire level_i,
  input wire noise_en_i,
  input wire rising_i,
  output reg event_o
);
  reg [`NOISE_SAMPLES-1:0] hist_q;
  reg filt_q;
  reg prev_q;
  wire all_hi;
  wire all_lo;
  wire cur;
  assign all_hi = &hist_q;
  assign all_lo = ~|hist_q;
  // Filtered level only moves when four samples agree
  assign cur = noise_en_i ? filt_q : level_i;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hist_q <= {`NOISE_SAMPLES{1'b0}};
      filt_q <= 1'b0;
      prev_q <= 1'b0;
      event_o <= 1'b0;
    end else begin
      hist_q <= {hist_q[`NOISE_SAMPLES-2:0], level_i};
      if (all_hi) begin
        filt_q <= 1'b1;
      end else if (all_lo) begin
        filt_q <= 1'b0;
      end
      prev_q <= cur;
      event_o <= rising_i ? (cur & ~prev_q) : (~cur & prev_q);
    end
  end
endmodule

// ---- verilog/pin_sync.v ----
// Three-stage synchroniser for an asynchronous pin
module pin_sync (
  input wire ref_clk_i,
  input wire rst_i,
  input wire pin_i,
  output reg level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // Level changes once second and third stages agree
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule

// ---- verilog/timer16.v ----
// 16-bit timer with compare, capture, PWM and an APB register slave
`include "timer16_defines.vh"
module timer16 (
  input wire ref_clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire count_pin_i,
  input wire capture_pin_i,
  input wire comparator_i,
  output reg compare_pin_a_o,
  output reg compare_pin_b_o,
  output reg compare_oe_a_o,
  output reg compare_oe_b_o,
  output reg irq_o
);
  // ==========================================================
  // Registers
  reg [7:0] timer1_control_a_q;
  reg [7:0] timer1_control_b_q;
  reg [15:0] count_q;
  reg [15:0] compare_value_a_q;
  reg [15:0] compare_value_b_q;
  reg [15:0] capture_value_q;
  reg [3:0] status_q;
  reg [3:0] mask_q;
  reg [9:0] presc_q;
  reg ext_prev_q;
  reg down_q;
  reg [1:0] pin_q;
  reg [15:0] cmp_live_a_q;
  reg [15:0] cmp_live_b_q;
  // Pin side and capture nets
  wire ext_level;
  wire pin_capt_lvl;
  wire comp_lvl;
  wire capt_event;
  // Decoded control fields
  wire [1:0] pwm_sel;
  wire [2:0] clk_sel;
  // Bus decode
  wire access;
  wire wr;
  // Count and compare datapath
  reg tick;
  reg [15:0] top;
  reg [15:0] cmp [0:1];
  wire [1:0] match;
  reg [1:0] mode [0:1];
  wire at_top;
  reg ovf;
  // Read path
  reg [31:0] rd_data;
  reg rd_ok;
  // Next-state values
  reg [15:0] count_d;
  reg down_d;
  // Event flags
  wire [3:0] set_bits;
  wire [3:0] clr_bits;
  genvar g;

  // Field decode and bus qualifiers
  assign pwm_sel = timer1_control_a_q[1:0];
  assign clk_sel = timer1_control_b_q[2:0];
  // Access taken on the first access edge, answered on the next
  assign access = psel_i & penable_i & ~pready_o;
  // Writes land at the edge where ready is seen high
  assign wr = psel_i & penable_i & pready_o & pwrite_i;

  // ==========================================================
  // Pin synchronisers and capture path
  pin_sync u_count_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(count_pin_i),
    .level_o(ext_level)
  );
  pin_sync u_capt_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(capture_pin_i),
    .level_o(pin_capt_lvl)
  );
  pin_sync u_comp_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(comparator_i),
    .level_o(comp_lvl)
  );
  // Comparator taken as capture source when ctrl B bit 5 is set
  capture_filter u_capt (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .level_i(timer1_control_b_q[`CB_COMP] ? comp_lvl : pin_capt_lvl),
    .noise_en_i(timer1_control_b_q[`CB_NOISE]),
    .rising_i(timer1_control_b_q[`CB_EDGE]),
    .event_o(capt_event)
  );

  // ==========================================================
  // Count tick selection
  always @* begin
    case (clk_sel)
      `CS_STOP: tick = 1'b0;
      `CS_DIV1: tick = 1'b1;
      `CS_DIV8: tick = (presc_q[2:0] == 3'h7);
      `CS_DIV64: tick = (presc_q[5:0] == 6'h3f);
      `CS_DIV256: tick = (presc_q[7:0] == 8'hff);
      `CS_DIV1024: tick = (presc_q == 10'h3ff);
      `CS_EXT_FALL: tick = ext_prev_q & ~ext_level;
      `CS_EXT_RISE: tick = ~ext_prev_q & ext_level;
      default: tick = 1'b0;
    endcase
  end

  // PWM top and compare matches
  always @* begin
    case (pwm_sel)
      `PWM_8: top = 16'h00ff;
      `PWM_9: top = 16'h01ff;
      `PWM_10: top = 16'h03ff;
      default: top = 16'hffff;
    endcase
    cmp[0] = cmp_live_a_q;
    cmp[1] = cmp_live_b_q;
    mode[0] = timer1_control_a_q[`CA_MODE_A_HI:`CA_MODE_A_LO];
    mode[1] = timer1_control_a_q[`CA_MODE_B_HI:`CA_MODE_B_LO];
  end

  // ==========================================================
  // Compare values in use
  // PWM takes new values only at top, so no pulse is cut short
  assign at_top = tick & ~down_q & (count_q >= top);
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_live_a_q <= 16'h0000;
      cmp_live_b_q <= 16'h0000;
    end else if (pwm_sel == `PWM_OFF || at_top) begin
      cmp_live_a_q <= compare_value_a_q;
      cmp_live_b_q <= compare_value_b_q;
    end
  end

  // ==========================================================
  // Per-channel compare match and pin action
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
      // Match only on a count tick, so a stopped timer never fires
      assign match[g] = tick & (count_q == (cmp[g] & top));
      // Pin level follows the mode field on each match
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_q[g] <= 1'b0;
        end else if (match[g]) begin
          if (pwm_sel != `PWM_OFF) begin
            // PWM: mode 10 clears upcounting, 11 sets upcounting
            if (mode[g][1]) begin
              pin_q[g] <= mode[g][0] ^ down_q;
            end
          end else begin
            case (mode[g])
              `CM_TOGGLE: pin_q[g] <= ~pin_q[g];
              `CM_CLEAR: pin_q[g] <= 1'b0;
              `CM_SET: pin_q[g] <= 1'b1;
              default: pin_q[g] <= pin_q[g];
            endcase
          end
        end
      end
    end
  endgenerate

  // Next count: up/down in PWM, up with optional clear otherwise
  always @* begin
    count_d = count_q;
    down_d = down_q;
    ovf = 1'b0;
    if (tick) begin
      if (pwm_sel != `PWM_OFF) begin
        if (!down_q && count_q >= top) begin
          down_d = 1'b1;
          count_d = top - 16'h0001;
        end else if (down_q && count_q == 16'h0000) begin
          down_d = 1'b0;
          count_d = 16'h0001;
          ovf = 1'b1;
        end else begin
          count_d = down_q ? count_q - 16'h0001 : count_q + 16'h0001;
        end
      end else if (timer1_control_b_q[`CB_CLEAR_A] && match[0]) begin
        count_d = 16'h0000;
      end else begin
        count_d = count_q + 16'h0001;
        ovf = (count_q == 16'hffff);
      end
    end
  end

  // ==========================================================
  // Counter, prescaler and capture register
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= 16'h0000;
      down_q <= 1'b0;
      presc_q <= 10'h000;
      ext_prev_q <= 1'b0;
      capture_value_q <= 16'h0000;
    end else begin
      presc_q <= presc_q + 10'h001;
      ext_prev_q <= ext_level;
      if (capt_event) begin
        capture_value_q <= count_q;
      end
      if (wr && paddr_i == `COUNT_ADDR) begin
        count_q <= pwdata_i[15:0];
        down_q <= 1'b0;
      end else begin
        count_q <= count_d;
        down_q <= down_d;
      end
    end
  end

  // Drive pins registered; PWM compare values in effect glitch-free at top
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      compare_pin_a_o <= 1'b0;
      compare_pin_b_o <= 1'b0;
      compare_oe_a_o <= 1'b0;
      compare_oe_b_o <= 1'b0;
    end else begin
      compare_pin_a_o <= pin_q[0];
      compare_pin_b_o <= pin_q[1];
      compare_oe_a_o <= (mode[0] != `CM_OFF) && (pwm_sel == `PWM_OFF || mode[0][1]);
      compare_oe_b_o <= (mode[1] != `CM_OFF) && (pwm_sel == `PWM_OFF || mode[1][1]);
    end
  end

  // ==========================================================
  // Read mux
  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr_i)
      `CTRL_A_ADDR: rd_data = {24'h00_0000, timer1_control_a_q};
      `CTRL_B_ADDR: rd_data = {24'h00_0000, timer1_control_b_q};
      `COUNT_ADDR: rd_data = {16'h0000, count_q};
      `CMP_A_ADDR: rd_data = {16'h0000, compare_value_a_q};
      `CMP_B_ADDR: rd_data = {16'h0000, compare_value_b_q};
      `CAPT_ADDR: rd_data = {16'h0000, capture_value_q};
      `STATUS_ADDR: rd_data = {28'h000_0000, status_q};
      `MASK_ADDR: rd_data = {28'h000_0000, mask_q};
      default: rd_ok = 1'b0;
    endcase
  end

  // APB answer: ready and error one cycle after the access is taken
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= access;
      pslverr_o <= access & ~rd_ok;
      // Read data stands until the next read
      if (access && !pwrite_i) begin
        prdata_o <= rd_data;
      end
    end
  end

  // Control and compare registers
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer1_control_a_q <= `CTRL_A_RESET;
      timer1_control_b_q <= 8'h00;
      compare_value_a_q <= 16'h0000;
      compare_value_b_q <= 16'h0000;
      mask_q <= 4'h0;
    end else begin
      if (wr) begin
        case (paddr_i)
          `CTRL_A_ADDR: timer1_control_a_q <= pwdata_i[7:0] & `CTRL_A_RW_MASK;
          `CTRL_B_ADDR: timer1_control_b_q <= pwdata_i[7:0] & `CTRL_B_RW_MASK;
          `CMP_A_ADDR: compare_value_a_q <= pwdata_i[15:0];
          `CMP_B_ADDR: compare_value_b_q <= pwdata_i[15:0];
          `MASK_ADDR: mask_q <= pwdata_i[3:0];
          default: mask_q <= mask_q;
        endcase
      end
    end
  end

  // ==========================================================
  // Event flags and interrupt
  // Hardware events raised this cycle
  assign set_bits = {capt_event, match[1], match[0], ovf};
  // Bits that software clears by writing ones
  assign clr_bits = (wr && paddr_i == `STATUS_ADDR) ? pwdata_i[3:0] : 4'h0;
  // Set wins over write-one-to-clear
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr_bits) | set_bits;
      irq_o <= |(status_q & mask_q);
    end
  end
endmodule
